//--- rtl/anr_cfg.sv
// Purpose: analogue node configuration registers with reset control.
// Assumes: ref_clk is the oscillator clock; link logic shares it.
// Notes:   requests are register numbers; at most one answer per request.
`timescale 1ns/1ps
`default_nettype none
`include "anr_map.svh"


module anr_cfg
    import anr_pkg::*;
#(
    parameter int SYS_RST_CYCLES = `ANR_SYS_RST_CYCLES,
    parameter int TILE_RST_CYCLES = `ANR_TILE_RST_CYCLES,
    parameter logic [1:0] MODE_PINS_RST = 2'h0
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // reset sources
    input wire logic ext_rst_pin_n,
    input wire logic brownout_pin,
    input wire logic watchdog_expired,
    input wire logic sleep_event,
    input wire logic clk_change_event,
    // configuration packets
    input wire anr_req_type cfg_req,
    output anr_rsp_type cfg_rsp,
    // link
    input wire anr_link_stat_type link_stat,
    output anr_link_ctl_type link_ctl,
    // reset outputs
    output logic sys_reset_out,
    output logic tile_reset_out,
    // usb control
    output logic usb_reg_access_en,
    output logic usb_enable,
    output logic usb_regs_clear,
    // processor mode pins
    output logic [1:0] mode_pin_out,
    output logic [1:0] mode_pin_oe,
    // frequency setting for timing-derived functions
    output logic [6:0] osc_mhz
);

    // ==========================================================
    // pin synchronisers
    // ==========================================================
    logic [1:0] ext_rst_sync_reg;
    logic [1:0] brownout_sync_reg;

    // only the second flop of each pair feeds logic; the first may be metastable
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ext_rst_sync_reg <= 2'h3;
            brownout_sync_reg <= 2'h0;
        end else begin
            ext_rst_sync_reg <= {ext_rst_sync_reg[0], ext_rst_pin_n};
            brownout_sync_reg <= {brownout_sync_reg[0], brownout_pin};
        end
    end

    // ==========================================================
    // register state
    // ==========================================================
    logic lock_reg;
    logic [15:0] node_id_reg;
    logic tri_reg;
    logic [1:0] mode_reg;
    logic usb_acc_reg;
    logic usb_en_reg;
    logic [6:0] osc_reg;
    logic err_reg;
    logic [10:0] sym_gap_reg;
    logic [10:0] tok_gap_reg;

    // ==========================================================
    // request decode
    // ==========================================================
    logic sys_hold;
    logic tile_hold;
    logic rd_c;
    logic wr_c;
    logic [31:0] wd_c;
    logic [7:0] addr_c;
    logic locked_wr_c;
    logic osc_ok_c;
    logic sw_sys_rst_c;
    logic sw_tile_rst_c;
    logic no_rsp_c;

    // requests during a system reset are dropped unanswered
    assign rd_c = cfg_req.valid && !cfg_req.write && !sys_hold;
    assign wr_c = cfg_req.valid && cfg_req.write && !sys_hold;
    assign wd_c = cfg_req.data;
    assign addr_c = cfg_req.addr;

    // locked registers refuse writes
    assign locked_wr_c = lock_reg && (addr_c == `ANR_NODE_CFG_NUM ||
                         addr_c == `ANR_LINK_NUM);

    assign osc_ok_c = wd_c[`ANR_OSC_MSB:0] >= `ANR_OSC_MIN &&
                      wd_c[`ANR_OSC_MSB:0] <= `ANR_OSC_MAX &&
                      wd_c[31:7] == 25'h0;

    assign sw_sys_rst_c = wr_c && addr_c == `ANR_RMC_NUM &&
                          wd_c[`ANR_SYS_RST_BIT];
    assign sw_tile_rst_c = wr_c && addr_c == `ANR_RMC_NUM &&
                           wd_c[`ANR_TILE_RST_BIT];

    // the reset may begin before any answer could leave
    assign no_rsp_c = sw_sys_rst_c || sw_tile_rst_c;

    // ==========================================================
    // reset generation
    // ==========================================================
    logic sys_start_c;
    logic tile_start_c;

    // pin held low keeps restarting the count
    assign sys_start_c = !ext_rst_sync_reg[1] ||
                         brownout_sync_reg[1] ||
                         watchdog_expired ||
                         sw_sys_rst_c;

    assign tile_start_c = sleep_event ||
                          clk_change_event ||
                          sw_tile_rst_c;

    // length counted in oscillator cycles, so slower clocks stretch it
    anr_hold_timer #(
        .COUNT(SYS_RST_CYCLES),
        .CNT_W(20)
    ) u_sys_timer (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .start(sys_start_c),
        .active(sys_hold)
    );

    // tile-only hold: configuration registers ride through it
    anr_hold_timer #(
        .COUNT(TILE_RST_CYCLES),
        .CNT_W(8)
    ) u_tile_timer (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .start(tile_start_c),
        .active(tile_hold)
    );

    // system scope covers the tiles as well
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            sys_reset_out <= 1'b0;
            tile_reset_out <= 1'b0;
        end else begin
            sys_reset_out <= sys_hold;
            tile_reset_out <= tile_hold || sys_hold;
        end
    end

    // ==========================================================
    // node configuration and identifier
    // ==========================================================
    always_ff @(posedge ref_clk) begin
        if (!rst_n || sys_hold) begin
            lock_reg <= 1'b0;
        end else if (wr_c && addr_c == `ANR_NODE_CFG_NUM && !lock_reg) begin
            lock_reg <= wd_c[`ANR_LOCK_BIT];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n || sys_hold) begin
            node_id_reg <= `ANR_ID_RST;
        end else if (wr_c && addr_c == `ANR_NODE_ID_NUM) begin
            node_id_reg <= wd_c[`ANR_ID_MSB:0];
        end
    end

    // ==========================================================
    // reset and mode control
    // ==========================================================
    always_ff @(posedge ref_clk) begin
        if (!rst_n || sys_hold) begin
            tri_reg <= 1'b0;
            mode_reg <= MODE_PINS_RST;
            usb_acc_reg <= 1'b0;
            usb_en_reg <= 1'b0;
        end else if (wr_c && addr_c == `ANR_RMC_NUM) begin
            tri_reg <= wd_c[`ANR_TRI_BIT];
            mode_reg <= wd_c[`ANR_MODE_MSB:`ANR_MODE_LSB];
            usb_acc_reg <= wd_c[`ANR_USB_ACC_BIT];
            usb_en_reg <= wd_c[`ANR_USB_EN_BIT];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            usb_reg_access_en <= 1'b0;
            usb_enable <= 1'b0;
            usb_regs_clear <= 1'b1;
            mode_pin_out <= 2'h0;
            mode_pin_oe <= 2'h0;
        end else begin
            usb_reg_access_en <= usb_acc_reg;
            usb_enable <= usb_en_reg;
            // usb registers held at reset values while disabled
            usb_regs_clear <= !usb_en_reg;
            mode_pin_out <= mode_reg;
            mode_pin_oe <= {2{!tri_reg}};
        end
    end

    // ==========================================================
    // oscillator frequency
    // ==========================================================
    always_ff @(posedge ref_clk) begin
        if (!rst_n || sys_hold) begin
            osc_reg <= `ANR_OSC_RST;
        end else if (wr_c && addr_c == `ANR_OSC_NUM && osc_ok_c) begin
            osc_reg <= wd_c[`ANR_OSC_MSB:0];
        end
    end

    // timing users scale from this value, so it is exported as is
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            osc_mhz <= `ANR_OSC_RST;
        end else begin
            osc_mhz <= osc_reg;
        end
    end

    // ==========================================================
    // link control and status
    // ==========================================================
    logic link_wr_c;
    logic err_set_c;

    assign link_wr_c = wr_c && addr_c == `ANR_LINK_NUM && !lock_reg;
    assign err_set_c = link_stat.overflow || link_stat.bad_token;

    // a new error in the reading cycle survives the clear
    always_ff @(posedge ref_clk) begin
        if (!rst_n || sys_hold) begin
            err_reg <= 1'b0;
        end else if (err_set_c) begin
            err_reg <= 1'b1;
        end else if (rd_c && addr_c == `ANR_LINK_NUM) begin
            err_reg <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n || sys_hold) begin
            sym_gap_reg <= `ANR_GAP_RST;
            tok_gap_reg <= `ANR_GAP_RST;
        end else if (link_wr_c) begin
            sym_gap_reg <= wd_c[`ANR_SYM_MSB:`ANR_SYM_LSB];
            tok_gap_reg <= wd_c[`ANR_TOK_MSB:`ANR_TOK_LSB];
        end
    end

    // command bits leave as one-cycle pulses and are never stored;
    // one process drives every field so the struct has a single driver
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            link_ctl.link_greeting_token <= 1'b0;
            link_ctl.credit_clear <= 1'b0;
            link_ctl.rx_resync <= 1'b0;
            link_ctl.symbol_gap <= `ANR_GAP_RST;
            link_ctl.token_gap <= `ANR_GAP_RST;
        end else begin
            link_ctl.link_greeting_token <= link_wr_c && wd_c[`ANR_LINK_GREETING_TOKEN_BIT];
            link_ctl.credit_clear <= link_wr_c &&
                                     wd_c[`ANR_LINK_GREETING_TOKEN_BIT];
            link_ctl.rx_resync <= link_wr_c && wd_c[`ANR_RESYNC_BIT];
            // gaps reach the link logic straight from flip-flops
            link_ctl.symbol_gap <= sym_gap_reg;
            link_ctl.token_gap <= tok_gap_reg;
        end
    end

    // ==========================================================
    // read data and answer
    // ==========================================================
    logic [31:0] rdata_c;
    logic ack_c;

    always_comb begin
        rdata_c = 32'h0000_0000;
        ack_c = 1'b1;
        case (addr_c)
            `ANR_NODE_CFG_NUM: begin
                rdata_c[`ANR_LOCK_BIT] = lock_reg;
                ack_c = !(cfg_req.write && locked_wr_c);
            end
            `ANR_NODE_ID_NUM: begin
                rdata_c[`ANR_ID_MSB:0] = node_id_reg;
            end
            `ANR_RMC_NUM: begin
                // reset request bits are write-only and read zero
                rdata_c[`ANR_TRI_BIT] = tri_reg;
                rdata_c[`ANR_MODE_MSB:`ANR_MODE_LSB] = mode_reg;
                rdata_c[`ANR_USB_ACC_BIT] = usb_acc_reg;
                rdata_c[`ANR_USB_EN_BIT] = usb_en_reg;
            end
            `ANR_OSC_NUM: begin
                rdata_c[`ANR_OSC_MSB:0] = osc_reg;
                ack_c = !cfg_req.write || osc_ok_c;
            end
            `ANR_LINK_NUM: begin
                rdata_c[`ANR_ERR_BIT] = err_reg;
                rdata_c[`ANR_ISSUED_BIT] = link_stat.issued_credit;
                rdata_c[`ANR_HELD_BIT] = link_stat.have_credit;
                rdata_c[`ANR_SYM_MSB:`ANR_SYM_LSB] = sym_gap_reg;
                rdata_c[`ANR_TOK_MSB:`ANR_TOK_LSB] = tok_gap_reg;
                ack_c = !(cfg_req.write && locked_wr_c);
            end
            default: begin
                ack_c = 1'b0;
            end
        endcase
    end

    // reads always answer outside a system reset; writes answer only when asked
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            cfg_rsp <= '0;
        end else begin
            cfg_rsp.valid <= rd_c ||
                             (wr_c && cfg_req.want_rsp && !no_rsp_c);
            cfg_rsp.ack <= ack_c;
            cfg_rsp.data <= rd_c ? rdata_c : 32'h0000_0000;
        end
    end

endmodule : anr_cfg

`default_nettype wire

//--- inc/anr_map.svh
// Purpose: register numbers, fields, reset values and counts of the
//          analogue node configuration block.
// Assumes: register numbers are packet addresses, not byte addresses.
// Notes:   definitions only.
//
// Summary of operation
// - 16-bit node identifier, read-write, resets zero
// - system reset and processor-tile reset scopes
// - reset pin or brown-out raises system reset
// - watchdog expiry raises system reset
// - sleep or clock change raises tile reset
// - system reset held 524,288 oscillator cycles
// - control bit 3 enables USB register access
// - control bit 2 enables USB, clears resets registers
// - control bit 1 starts tile reset, self-clearing
// - reset-bit writes send no response packet
// - 7-bit oscillator MHz field, resets to 25
// - frequency outside 5..100 ignored and NACKed
// - software programs frequency; timing derives from it
// - link error bit 27 sticky, clears on read
// - bits 26, 25 report credit issued, held
// - bit 24 clears credit, sends greeting token
// - bit 23 resyncs link receiver to token start
// - bits 21:11 symbol spacing, reset 1
// - bits 10:0 token spacing, reset 1
// - lock bit blocks node config and link changes
`ifndef ANR_MAP_SVH
`define ANR_MAP_SVH

`define ANR_ADDR_W 8
`define ANR_DATA_W 32

// register numbers
`define ANR_NODE_CFG_NUM 8'h04
`define ANR_NODE_ID_NUM 8'h05
`define ANR_RMC_NUM 8'h50
`define ANR_OSC_NUM 8'h51
`define ANR_LINK_NUM 8'h80

// field positions
`define ANR_LOCK_BIT 31
`define ANR_ID_MSB 15
`define ANR_TRI_BIT 24
`define ANR_MODE_MSB 17
`define ANR_MODE_LSB 16
`define ANR_USB_ACC_BIT 3
`define ANR_USB_EN_BIT 2
`define ANR_TILE_RST_BIT 1
`define ANR_SYS_RST_BIT 0
`define ANR_OSC_MSB 6
`define ANR_ERR_BIT 27
`define ANR_ISSUED_BIT 26
`define ANR_HELD_BIT 25
`define ANR_LINK_GREETING_TOKEN_BIT 24
`define ANR_RESYNC_BIT 23
`define ANR_SYM_MSB 21
`define ANR_SYM_LSB 11
`define ANR_TOK_MSB 10
`define ANR_TOK_LSB 0

// reset values and limits
`define ANR_ID_RST 16'h0000
`define ANR_OSC_RST 7'h19
`define ANR_OSC_MIN 7'h05
`define ANR_OSC_MAX 7'h64
`define ANR_GAP_RST 11'h001

// timing counts, in oscillator cycles
`define ANR_SYS_RST_CYCLES 524288
`define ANR_TILE_RST_CYCLES 16

`endif

//--- inc/anr_pkg.sv
// Purpose: types shared by the analogue node configuration block.
// Assumes: anr_map.svh supplies the widths.
// Notes:   request and answer travel as packed structs.
`include "anr_map.svh"

package anr_pkg;

    // configuration request from the packet layer
    typedef struct packed {
        logic valid;
        logic write;
        logic want_rsp;
        logic [`ANR_ADDR_W-1:0] addr;
        logic [`ANR_DATA_W-1:0] data;
    } anr_req_type;

    // answer: ack high for ACK, low for NACK
    typedef struct packed {
        logic valid;
        logic ack;
        logic [`ANR_DATA_W-1:0] data;
    } anr_rsp_type;

    // events and status from the link logic
    typedef struct packed {
        logic overflow;
        logic bad_token;
        logic issued_credit;
        logic have_credit;
    } anr_link_stat_type;

    // commands and spacing to the link logic
    typedef struct packed {
        logic link_greeting_token;
        logic credit_clear;
        logic rx_resync;
        logic [10:0] symbol_gap;
        logic [10:0] token_gap;
    } anr_link_ctl_type;

endpackage : anr_pkg

//--- rtl/anr_hold_timer.sv
// Purpose: hold a reset level for a fixed number of cycles.
// Assumes: start is a same-clock level; held start keeps restarting.
// Notes:   active rises the edge after start, falls COUNT edges later.
`timescale 1ns/1ps
`default_nettype none

module anr_hold_timer #(
    parameter int COUNT = 16,
    parameter int CNT_W = 20
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // control
    input wire logic start,
    // status
    output logic active
);

    logic [CNT_W-1:0] cnt_reg;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            cnt_reg <= '0;
            active <= 1'b0;
        end else if (start) begin
            cnt_reg <= CNT_W'(COUNT - 1);
            active <= 1'b1;
        end else if (cnt_reg != '0) begin
            cnt_reg <= cnt_reg - 1'b1;
        end else begin
            active <= 1'b0;
        end
    end

endmodule : anr_hold_timer

`default_nettype wire

//--- sim/anr_cfg_monitor.sv
// Purpose: port assertions for the analogue node configuration block
// Assumes: one clock, rst_n synchronous active low
// Notes:   bound to anr_cfg at the foot of this file
`timescale 1ns/1ps
`default_nettype none
// ====================
// checker
module anr_cfg_monitor
    import anr_pkg::*;
#(
    parameter int SYS_RST_CYCLES = 64
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // watched ports
    input wire logic sleep_event,
    input wire anr_req_type cfg_req,
    input wire anr_rsp_type cfg_rsp,
    input wire anr_link_ctl_type link_ctl,
    input wire logic sys_reset_out,
    input wire logic tile_reset_out,
    input wire logic usb_regs_clear,
    input wire logic [6:0] osc_mhz
);
    logic wr;
    logic [31:0] d;
    logic [31:0] held_reg;
    assign wr = cfg_req.valid && cfg_req.write;
    assign d = cfg_req.data;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // restarts only lengthen a reset, so only a lower bound is checked
    always_ff @(posedge ref_clk) begin
        held_reg <= sys_reset_out ? held_reg + 32'h1 : 32'h0;
    end
    chk_read_answered: assert property (
        cfg_req.valid && !cfg_req.write |=> cfg_rsp.valid || sys_reset_out)
        else $error("read not answered");
    chk_reset_silent: assert property (
        wr && cfg_req.addr == 8'h50 && d[1:0] != 2'h0 |=> !cfg_rsp.valid)
        else $error("reset write answered");
    chk_osc_refused: assert property (
        wr && cfg_req.want_rsp && cfg_req.addr == 8'h51 && (d < 32'h5 || d > 32'h64)
        |=> (cfg_rsp.valid && !cfg_rsp.ack) || sys_reset_out)
        else $error("bad frequency not refused");
    chk_osc_taken: assert property (
        wr && cfg_req.addr == 8'h51 && d >= 32'h5 && d <= 32'h64
        |-> ##2 (osc_mhz == $past(d[6:0], 2) || sys_reset_out))
        else $error("frequency not taken");
    chk_greet_pulse: assert property (
        wr && cfg_req.addr == 8'h80 && d[24] ##1 cfg_rsp.valid && cfg_rsp.ack
        |-> link_ctl.link_greeting_token && link_ctl.credit_clear ##1 !link_ctl.link_greeting_token)
        else $error("greeting pulse wrong");
    chk_resync_pulse: assert property (
        wr && cfg_req.addr == 8'h80 && d[23] ##1 cfg_rsp.valid && cfg_rsp.ack
        |-> link_ctl.rx_resync ##1 !link_ctl.rx_resync)
        else $error("resync pulse wrong");
    chk_locked_still: assert property (
        wr && cfg_req.addr == 8'h80 ##1 cfg_rsp.valid && !cfg_rsp.ack
        |-> !link_ctl.link_greeting_token && !link_ctl.rx_resync ##1 $stable(link_ctl.token_gap))
        else $error("refused link write acted");
    chk_usb_cleared: assert property (
        wr && cfg_req.addr == 8'h50 && d[2:0] == 3'h0 |-> ##2 usb_regs_clear)
        else $error("usb not cleared");
    chk_sys_start: assert property (
        wr && cfg_req.addr == 8'h50 && d[0] |-> ##2 sys_reset_out && tile_reset_out)
        else $error("system reset not started");
    chk_tile_start: assert property (
        (wr && cfg_req.addr == 8'h50 && d[1]) || sleep_event |-> ##[1:3] tile_reset_out)
        else $error("tile reset not started");
    chk_sys_length: assert property (
        $fell(sys_reset_out) |-> held_reg >= SYS_RST_CYCLES)
        else $error("system reset too short");
endmodule : anr_cfg_monitor
bind anr_cfg anr_cfg_monitor #(.SYS_RST_CYCLES(SYS_RST_CYCLES)) u_mon (.ref_clk, .rst_n,
    .sleep_event, .cfg_req, .cfg_rsp, .link_ctl, .sys_reset_out, .tile_reset_out,
    .usb_regs_clear, .osc_mhz);
`default_nettype wire

//--- sim/anr_link_model.sv
// Purpose: far end of the serial link: credit return and fault events
// Assumes: shares ref_clk; fault_req bits are one-cycle commands
// Notes:   credit comes back a fixed delay after a greeting
`timescale 1ns/1ps
`default_nettype none
// ====================
// remote link model
module anr_link_model
    import anr_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // link side of the block
    input wire anr_link_ctl_type link_ctl,
    output var anr_link_stat_type link_stat,
    // fault injection
    input wire logic [1:0] fault_req
);
    logic [2:0] wait_reg;
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            link_stat <= '0;
            wait_reg <= 3'h0;
        end else begin
            link_stat.overflow <= fault_req[0];
            link_stat.bad_token <= fault_req[1];
            if (link_ctl.credit_clear) begin
                link_stat.have_credit <= 1'h0;
            end
            // a slow remote: credit only after several cycles
            if (link_ctl.link_greeting_token) begin
                wait_reg <= 3'h6;
            end else if (wait_reg == 3'h1) begin
                link_stat.have_credit <= 1'h1;
                link_stat.issued_credit <= 1'h1;
                wait_reg <= 3'h0;
            end else if (wait_reg != 3'h0) begin
                wait_reg <= wait_reg - 3'h1;
            end
        end
    end
endmodule : anr_link_model
`default_nettype wire

//--- sim/anr_cfg_tb_top.sv
// Purpose: self-checking bench for anr_cfg
// Assumes: short reset counts; answers checked from a queue
// Notes:   random data from an lfsr with a fixed start
`timescale 1ns/1ps
`default_nettype none
// ====================
// bench
module anr_cfg_tb_top
    import anr_pkg::*;
;
    localparam int SYS_N = 64;
    localparam logic [33:0] ACK0 = 34'h3_0000_0000;
    localparam logic [33:0] NAK = 34'h2_0000_0000;
    logic ref_clk, rst_n, ext_rst_pin_n, brownout_pin, watchdog_expired;
    logic sleep_event, clk_change_event, sys_reset_out, tile_reset_out;
    logic usb_reg_access_en, usb_enable, usb_regs_clear, ok_b;
    logic [1:0] mode_pin_out, mode_pin_oe, fault_req;
    logic [6:0] osc_mhz, last;
    logic [31:0] seed_reg, v, g;
    logic [31:0] osc_tab [6];
    logic [32:0] exp_q [$];
    anr_req_type cfg_req;
    anr_rsp_type cfg_rsp;
    anr_link_stat_type link_stat;
    anr_link_ctl_type link_ctl;
    int fail_count = 0;
    int tests_run = 0;
    int cyc = 0;
    anr_cfg #(.SYS_RST_CYCLES(SYS_N), .TILE_RST_CYCLES(4)) dut (
        .ref_clk, .rst_n, .ext_rst_pin_n, .brownout_pin, .watchdog_expired,
        .sleep_event, .clk_change_event, .cfg_req, .cfg_rsp, .link_stat,
        .link_ctl, .sys_reset_out, .tile_reset_out, .usb_reg_access_en,
        .usb_enable, .usb_regs_clear, .mode_pin_out, .mode_pin_oe, .osc_mhz);
    anr_link_model peer (.ref_clk, .rst_n, .link_ctl, .link_stat, .fault_req);
    initial begin
        ref_clk = 1'h0;
        forever #4 ref_clk = ~ref_clk;
    end
    function automatic logic [31:0] rnd();
        seed_reg = {seed_reg[30:0], seed_reg[31] ^ seed_reg[21] ^ seed_reg[1] ^ seed_reg[0]};
        return seed_reg;
    endfunction : rnd
    task automatic chk(input logic ok, input string m);
        tests_run++;
        if (ok !== 1'h1) begin
            fail_count++;
            $display("mismatch %0t %s", $time, m);
        end
    endtask : chk
    task automatic end_sim();
        chk(exp_q.size() == 0, "answers missing");
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : end_sim
    // request stays up into the next call so back-to-back requests work
    task automatic req(input logic w, input logic [7:0] a, input logic [31:0] d,
            input logic [33:0] e);
        cfg_req <= '{1'h1, w, 1'h1, a, d};
        if (e[33]) exp_q.push_back(e[32:0]);
        @(posedge ref_clk);
    endtask : req
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        req(1'h0, a, 32'h0, {2'h3, x});
    endtask : rd
    task automatic idle(input int n);
        cfg_req.valid <= 1'h0;
        repeat (n) @(posedge ref_clk);
    endtask : idle
    task automatic wait_for(input logic tile, input logic val, input int lim);
        int n;
        n = 0;
        while ((tile ? tile_reset_out : sys_reset_out) !== val && n < lim) begin
            @(posedge ref_clk);
            n++;
        end
        chk(n < lim, "reset level");
    endtask : wait_for
    always @(posedge ref_clk) begin
        if (cfg_rsp.valid === 1'h1) begin
            if (exp_q.size() == 0) chk(1'h0, "answer not expected");
            else chk({cfg_rsp.ack, cfg_rsp.data} === exp_q.pop_front(), "answer");
        end
    end
    // the closing call stays last so nothing runs after the finish
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fail_count++;
            $display("mismatch %0t timeout", $time);
            end_sim();
        end
    end
    initial begin
        rst_n = 1'h0;
        ext_rst_pin_n = 1'h1;
        brownout_pin = 1'h0;
        watchdog_expired = 1'h0;
        sleep_event = 1'h0;
        clk_change_event = 1'h0;
        fault_req = 2'h0;
        cfg_req = '0;
        seed_reg = 32'h0001_5200;
        repeat (6) @(posedge ref_clk);
        rst_n <= 1'h1;
        @(posedge ref_clk);
        chk(usb_regs_clear === 1'h1 && osc_mhz === 7'h19, "reset outputs");
        rd(8'h05, 32'h0);
        rd(8'h80, 32'h801);
        req(1'h0, 8'h33, 32'h0, NAK);
        v = rnd();
        req(1'h1, 8'h05, v, ACK0);
        rd(8'h05, {16'h0, v[15:0]});
        osc_tab = '{32'h0, 32'h4, 32'h5, 32'h64, 32'h65, 32'h180};
        osc_tab[0] = 32'h5 + rnd() % 32'h60;
        last = 7'h19;
        foreach (osc_tab[i]) begin
            g = osc_tab[i];
            ok_b = g >= 32'h5 && g <= 32'h64;
            if (ok_b) last = g[6:0];
            req(1'h1, 8'h51, g, ok_b ? ACK0 : NAK);
            rd(8'h51, {25'h0, last});
        end
        idle(2);
        chk(osc_mhz === last, "frequency out");
        req(1'h1, 8'h50, 32'h0003_000C, ACK0);
        rd(8'h50, 32'h0003_000C);
        idle(2);
        chk(usb_reg_access_en === 1'h1 && usb_enable === 1'h1, "usb on");
        chk(usb_regs_clear === 1'h0 && mode_pin_oe === 2'h3, "usb on");
        chk(mode_pin_out === 2'h3, "mode pins out");
        req(1'h1, 8'h50, 32'h0100_0000, ACK0);
        idle(2);
        chk(usb_enable === 1'h0 && usb_regs_clear === 1'h1, "usb off");
        chk(usb_reg_access_en === 1'h0 && mode_pin_oe === 2'h0, "pins off");
        chk(mode_pin_out === 2'h0, "mode pins off");
        g = rnd() & 32'h003F_FFFF;
        req(1'h1, 8'h80, g | 32'h0100_0000, ACK0);
        req(1'h1, 8'h80, g | 32'h0080_0000, ACK0);
        idle(12);
        chk(link_ctl.symbol_gap === g[21:11], "symbol gap out");
        chk(link_ctl.token_gap === g[10:0], "token gap out");
        rd(8'h80, g | 32'h0600_0000);
        for (int i = 0; i < 2; i++) begin
            fault_req <= 2'h1 << i;
            idle(1);
            fault_req <= 2'h0;
            idle(3);
            rd(8'h80, g | 32'h0E00_0000);
            rd(8'h80, g | 32'h0600_0000);
        end
        req(1'h1, 8'h04, 32'h8000_0000, ACK0);
        req(1'h1, 8'h80, 32'h0100_0000, NAK);
        rd(8'h80, g | 32'h0600_0000);
        req(1'h1, 8'h50, 32'h2, 34'h0);
        idle(1);
        wait_for(1'h1, 1'h1, 4);
        chk(sys_reset_out === 1'h0, "tile only");
        wait_for(1'h1, 1'h0, 8);
        for (int i = 0; i < 2; i++) begin
            sleep_event <= (i == 0);
            clk_change_event <= (i == 1);
            idle(1);
            sleep_event <= 1'h0;
            clk_change_event <= 1'h0;
            wait_for(1'h1, 1'h1, 4);
            chk(sys_reset_out === 1'h0, "tile only");
            wait_for(1'h1, 1'h0, 8);
        end
        req(1'h1, 8'h50, 32'h1, 34'h0);
        idle(1);
        wait_for(1'h0, 1'h1, 4);
        chk(tile_reset_out === 1'h1, "tile in system reset");
        wait_for(1'h0, 1'h0, SYS_N + 4);
        rd(8'h51, 32'h19);
        rd(8'h04, 32'h0);
        idle(2);
        for (int i = 0; i < 3; i++) begin
            watchdog_expired <= (i == 0);
            brownout_pin <= (i == 1);
            ext_rst_pin_n <= (i != 2);
            idle(3);
            watchdog_expired <= 1'h0;
            brownout_pin <= 1'h0;
            ext_rst_pin_n <= 1'h1;
            wait_for(1'h0, 1'h1, 4);
            wait_for(1'h0, 1'h0, SYS_N + 8);
        end
        end_sim();
    end
endmodule : anr_cfg_tb_top
`default_nettype wire
